// ### eveeu_regs.vh
// offsets, field positions, reset values and vector numbers of the exception and edge event unit
`ifndef EVEEU_REGS_VH
`define EVEEU_REGS_VH

// register word offsets (byte addresses)
`define EVEEU_OFS_INTEN    8'h00
`define EVEEU_OFS_EVEN     8'h04
`define EVEEU_OFS_RTEN     8'h08
`define EVEEU_OFS_FTEN     8'h0c
`define EVEEU_OFS_SWTRIG   8'h10
`define EVEEU_OFS_PEND     8'h14
`define EVEEU_OFS_SYSPRIO  8'h18
`define EVEEU_OFS_IRQPRIO  8'h1c
`define EVEEU_OFS_STATUS   8'h20

// reset values
`define EVEEU_RST_LINES    23'h000000
`define EVEEU_RST_SYSPRIO  16'h0000
`define EVEEU_RST_IRQPRIO  4'hf

// status register fields
`define EVEEU_ST_VEC_LSB   0
`define EVEEU_ST_ACT_BIT   8

// line counts
`define EVEEU_NUM_LINES    23
`define EVEEU_NUM_PINS     16
`define EVEEU_NUM_INTERN   8
`define EVEEU_NUM_IRQ      52

// system exception vector numbers, vector address is number times four
`define EVEEU_VEC_BUSFLT   7'h05
`define EVEEU_VEC_USEFLT   7'h06
`define EVEEU_VEC_SUPERVISOR_CALL   7'h0b
`define EVEEU_VEC_PENDABLE_SERVICE   7'h0e
`define EVEEU_VEC_IRQ0     7'h10

// merged peripheral interrupt numbers
`define EVEEU_IRQ_LVD      1
`define EVEEU_IRQ_LINE01   5
`define EVEEU_IRQ_LINE23   6
`define EVEEU_IRQ_LINE415  7
`define EVEEU_IRQ_DMA12    10
`define EVEEU_IRQ_ADCCMP   12
`define EVEEU_IRQ_ADVTIM   13
`define EVEEU_IRQ_USBLOW   37
`define EVEEU_IRQ_USBWAKE  42
`define EVEEU_IRQ_DMA56    48

// edge lines feeding dedicated interrupts
`define EVEEU_LINE_LVD     16
`define EVEEU_LINE_USBWAKE 18

// last word index of the automatic stack frame; the frame is eight words
`define EVEEU_FRAME_WORDS  3'h7

`endif

// ### eveeu_top.v
// exception vector sequencer, interrupt merge map and edge event unit with wishbone registers
`timescale 1ns/1ps
`include "eveeu_regs.vh"

// Function
// R01: On exception entry push state automatically; pop it automatically at handler end.
// R02: Vector fetch happens in parallel with the first state push.
// R03: Pending request at handler end chains straight in, skipping pop and push.
// R04: Bus access fault uses vector 5, address 0x14, programmable priority.
// R05: Illegal use fault uses vector 6, address 0x18, programmable priority.
// R06: Supervisor call uses vector 11, address 0x2c, programmable priority.
// R07: Pendable service uses vector 14, address 0x38, programmable priority.
// R08: Advanced timer break, update, trigger, commutation merge onto IRQ 13.
// R09: DMA channels one and two merge onto IRQ 10.
// R10: ADC and both comparators merge onto IRQ 12.
// R11: DMA channels five and six merge onto IRQ 48.
// R12: USB device port low priority requests go to IRQ 37.
// R13: USB device wake-up through the edge unit goes to IRQ 42.
// R14: Twenty-three independent edge detectors produce interrupts or events.
// R15: Each detector triggers on rising, falling or both edges.
// R16: Trigger and mask settings are independent per detector.
// R17: Inputs are sixteen pin lines plus eight internal module lines; the code wires only internalLine[6:0] and leaves internalLine[7] as a spare.
// R18: Each edge gives a maskable interrupt and a separately maskable event.
// R19: An enabled edge or event wakes the processor from sleep.
// R20: Software clears pending flags; flags are set only for interrupts.
// R21: Software trigger bit raises enabled interrupt or event like an edge.
// R22: Rise and fall enables together trigger on either transition.
// R23: Inputs synchronised, compared with previous sample, events single-cycle pulses.
module eveeu_top (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        clkEn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [15:0] pinLine,
  input  wire [7:0]  internalLine,
  input  wire        busFaultReq,
  input  wire        illegalUseReq,
  input  wire        supervisorCallReq,
  input  wire        pendServiceReq,
  input  wire [3:0]  advTimerReq,
  input  wire [1:0]  dma12Req,
  input  wire        adcReq,
  input  wire [1:0]  comparatorReq,
  input  wire [1:0]  dma56Req,
  input  wire        usbLowReq,
  input  wire        handlerDone,
  output reg  [51:0] irqReq,
  output reg  [22:0] eventPulse,
  output reg         wakeReq,
  output reg         stackPush,
  output reg         stackPop,
  output reg         vecFetch,
  output reg  [31:0] vecAddr,
  output reg  [6:0]  activeVec,
  output reg         inHandler,
  output reg         tailChain
);

  localparam NL = `EVEEU_NUM_LINES;

  // sequencer states, one-hot
  localparam [3:0] ST_IDLE    = 4'h1;
  localparam [3:0] ST_STACK   = 4'h2;
  localparam [3:0] ST_ACTIVE  = 4'h4;
  localparam [3:0] ST_UNSTACK = 4'h8;

  // software registers
  reg  [NL-1:0] intEn;
  reg  [NL-1:0] evtEn;
  reg  [NL-1:0] rise_trigger_enable;
  reg  [NL-1:0] fall_trigger_enable;
  reg  [NL-1:0] line_pending_flag;
  reg  [15:0]   sysPrio;
  reg  [3:0]    irqPrio;

  // edge detector state
  reg  [NL-1:0] syncA;
  reg  [NL-1:0] syncB;
  reg  [NL-1:0] prevSample;
  wire [NL-1:0] rawLine;
  wire [NL-1:0] hwEdge;
  wire [NL-1:0] trig;

  // sequencer state
  reg  [3:0]    state;
  reg  [2:0]    wordCnt;
  reg  [3:0]    sysPend;
  reg  [3:0]    sysTaken;

  // bus decode
  wire          busReq;
  wire          wrStb;
  wire [31:0]   wMask;
  reg  [31:0]   rdData;
  reg  [NL-1:0] softTrig;
  reg  [NL-1:0] pendClr;
  reg  [51:0]   next_irqReq;

  // arbitration results
  reg           bestValid;
  reg  [3:0]    bestPri;
  reg  [6:0]    bestVec;
  reg  [3:0]    bestSys;
  reg           irqAny;
  reg  [6:0]    irqIdx;
  // each combinational loop keeps its own index, so no variable has two drivers
  integer       k;
  integer       sysIdx;

  // pins in the low lines, internal modules above; the top internal input is a spare
  assign rawLine = {internalLine[6:0], pinLine}; // [R17]

  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrStb  = busReq & wb_we_i;
  assign wMask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // per-line synchroniser, previous sample and edge qualification
  genvar g;
  generate
    for (g = 0; g < NL; g = g + 1) begin : gLine
      assign hwEdge[g] = (rise_trigger_enable[g] & syncB[g] & ~prevSample[g])   // [R15] [R16]
                       | (fall_trigger_enable[g] & ~syncB[g] & prevSample[g]);  // [R22]
      assign trig[g]   = hwEdge[g] | softTrig[g]; // [R21]
    end
  endgenerate

  // write-only trigger and write-one-to-clear strobes, decoded combinationally
  always @* begin
    softTrig = {NL{1'b0}};
    pendClr  = {NL{1'b0}};
    if (wrStb && wb_adr_i == `EVEEU_OFS_SWTRIG)
      softTrig = wb_dat_i[NL-1:0] & wMask[NL-1:0]; // [R21]
    if (wrStb && wb_adr_i == `EVEEU_OFS_PEND)
      pendClr = wb_dat_i[NL-1:0] & wMask[NL-1:0]; // [R20]
  end

  // read mux; unmapped addresses answer with zero
  always @* begin
    rdData = 32'h00000000;
    case (wb_adr_i)
      `EVEEU_OFS_INTEN:   rdData[NL-1:0] = intEn;
      `EVEEU_OFS_EVEN:    rdData[NL-1:0] = evtEn;
      `EVEEU_OFS_RTEN:    rdData[NL-1:0] = rise_trigger_enable;
      `EVEEU_OFS_FTEN:    rdData[NL-1:0] = fall_trigger_enable;
      `EVEEU_OFS_PEND:    rdData[NL-1:0] = line_pending_flag;
      `EVEEU_OFS_SYSPRIO: rdData[15:0]   = sysPrio;
      `EVEEU_OFS_IRQPRIO: rdData[3:0]    = irqPrio;
      `EVEEU_OFS_STATUS: begin
        rdData[`EVEEU_ST_VEC_LSB+6:`EVEEU_ST_VEC_LSB] = activeVec;
        rdData[`EVEEU_ST_ACT_BIT]                    = inHandler;
      end
      default:            rdData = 32'h00000000;
    endcase
  end

  // interrupt merge map toward the vector controller
  always @* begin
    next_irqReq = 52'h0000000000000;
    next_irqReq[`EVEEU_IRQ_LVD]     = line_pending_flag[`EVEEU_LINE_LVD];
    next_irqReq[`EVEEU_IRQ_LINE01]  = |line_pending_flag[1:0];
    next_irqReq[`EVEEU_IRQ_LINE23]  = |line_pending_flag[3:2];
    next_irqReq[`EVEEU_IRQ_LINE415] = |line_pending_flag[15:4];
    next_irqReq[`EVEEU_IRQ_DMA12]   = |dma12Req;                  // [R09]
    next_irqReq[`EVEEU_IRQ_ADCCMP]  = adcReq | (|comparatorReq);  // [R10]
    next_irqReq[`EVEEU_IRQ_ADVTIM]  = |advTimerReq;               // [R08]
    next_irqReq[`EVEEU_IRQ_USBLOW]  = usbLowReq;                  // [R12]
    next_irqReq[`EVEEU_IRQ_USBWAKE] = line_pending_flag[`EVEEU_LINE_USBWAKE]; // [R13]
    next_irqReq[`EVEEU_IRQ_DMA56]   = |dma56Req;                  // [R11]
  end

  // lowest numbered pending interrupt wins among peripherals
  always @* begin
    irqAny = 1'b0;
    irqIdx = 7'h00;
    for (k = `EVEEU_NUM_IRQ - 1; k >= 0; k = k - 1) begin
      if (irqReq[k]) begin
        irqAny = 1'b1;
        irqIdx = k[6:0];
      end
    end
  end

  // best candidate: lower priority value wins, system exceptions win ties
  always @* begin
    bestValid = 1'b0;
    bestPri   = 4'hf;
    bestVec   = 7'h00;
    bestSys   = 4'h0;
    for (sysIdx = 0; sysIdx < 4; sysIdx = sysIdx + 1) begin
      if (sysPend[sysIdx] && (!bestValid || sysPrio[sysIdx*4 +: 4] < bestPri)) begin
        bestValid = 1'b1;
        bestPri   = sysPrio[sysIdx*4 +: 4];
        bestSys   = 4'h0;
        bestSys[sysIdx] = 1'b1;
        case (sysIdx)
          0:       bestVec = `EVEEU_VEC_BUSFLT;  // [R04]
          1:       bestVec = `EVEEU_VEC_USEFLT;  // [R05]
          2:       bestVec = `EVEEU_VEC_SUPERVISOR_CALL;  // [R06]
          default: bestVec = `EVEEU_VEC_PENDABLE_SERVICE;  // [R07]
        endcase
      end
    end
    if (irqAny && (!bestValid || irqPrio < bestPri)) begin
      bestValid = 1'b1;
      bestPri   = irqPrio;
      bestVec   = `EVEEU_VEC_IRQ0 + irqIdx;
      bestSys   = 4'h0;
    end
  end

  // wishbone slave: one wait state, ack drops the cycle after it is given
  always @(posedge ref_clk) begin
    if (srst) begin
      wb_ack_o            <= 1'b0;
      wb_dat_o            <= 32'h00000000;
      intEn               <= `EVEEU_RST_LINES;
      evtEn               <= `EVEEU_RST_LINES;
      rise_trigger_enable <= `EVEEU_RST_LINES;
      fall_trigger_enable <= `EVEEU_RST_LINES;
      sysPrio             <= `EVEEU_RST_SYSPRIO;
      irqPrio             <= `EVEEU_RST_IRQPRIO;
    end else if (clkEn) begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? rdData : 32'h00000000;
      if (wrStb) begin
        case (wb_adr_i)
          `EVEEU_OFS_INTEN:   intEn <= (intEn & ~wMask[NL-1:0]) | (wb_dat_i[NL-1:0] & wMask[NL-1:0]); // [R16]
          `EVEEU_OFS_EVEN:    evtEn <= (evtEn & ~wMask[NL-1:0]) | (wb_dat_i[NL-1:0] & wMask[NL-1:0]); // [R16]
          `EVEEU_OFS_RTEN:    rise_trigger_enable <= (rise_trigger_enable & ~wMask[NL-1:0])
                                                   | (wb_dat_i[NL-1:0] & wMask[NL-1:0]);
          `EVEEU_OFS_FTEN:    fall_trigger_enable <= (fall_trigger_enable & ~wMask[NL-1:0])
                                                   | (wb_dat_i[NL-1:0] & wMask[NL-1:0]);
          `EVEEU_OFS_SYSPRIO: sysPrio <= (sysPrio & ~wMask[15:0]) | (wb_dat_i[15:0] & wMask[15:0]);
          `EVEEU_OFS_IRQPRIO: if (wb_sel_i[0]) irqPrio <= wb_dat_i[3:0];
          default: ;
        endcase
      end
    end
  end

  // edge detectors: two-flop synchroniser then a previous-sample register
  always @(posedge ref_clk) begin
    if (srst) begin
      syncA             <= {NL{1'b0}};
      syncB             <= {NL{1'b0}};
      prevSample        <= {NL{1'b0}};
      line_pending_flag <= {NL{1'b0}};
      eventPulse        <= {NL{1'b0}};
      wakeReq           <= 1'b0;
      irqReq            <= 52'h0000000000000;
    end else if (clkEn) begin
      syncA      <= rawLine;    // [R23]
      syncB      <= syncA;      // [R23]
      prevSample <= syncB;      // [R23]
      // a new trigger in the clearing cycle keeps the flag set
      line_pending_flag <= (line_pending_flag & ~pendClr) | (trig & intEn); // [R14] [R18] [R20]
      eventPulse <= trig & evtEn;                                          // [R18] [R23]
      wakeReq    <= |(trig & (intEn | evtEn));                             // [R19]
      irqReq     <= next_irqReq;
    end
  end

  // exception sequencer: stack, vector fetch, handler, unstack or chain
  always @(posedge ref_clk) begin
    if (srst) begin
      state     <= ST_IDLE;
      wordCnt   <= 3'h0;
      sysPend   <= 4'h0;
      stackPush <= 1'b0;
      stackPop  <= 1'b0;
      vecFetch  <= 1'b0;
      vecAddr   <= 32'h00000000;
      activeVec <= 7'h00;
      inHandler <= 1'b0;
      tailChain <= 1'b0;
    end else if (clkEn) begin
      vecFetch  <= 1'b0;
      tailChain <= 1'b0;
      // a request arriving while its bit is taken stays pending
      sysPend <= (sysPend & ~sysTaken)
               | {pendServiceReq, supervisorCallReq, illegalUseReq, busFaultReq};
      case (state)
        ST_IDLE: begin
          if (bestValid) begin
            state     <= ST_STACK;
            wordCnt   <= 3'h0;
            stackPush <= 1'b1;                        // [R01]
            vecFetch  <= 1'b1;                        // [R02]
            vecAddr   <= {23'h000000, bestVec, 2'b00};
            activeVec <= bestVec;
          end
        end
        ST_STACK: begin
          // vector was fetched alongside the first push, so entry costs only the frame
          if (wordCnt == `EVEEU_FRAME_WORDS) begin
            stackPush <= 1'b0;
            inHandler <= 1'b1;
            state     <= ST_ACTIVE;
          end else begin
            wordCnt <= wordCnt + 3'h1;
          end
        end
        ST_ACTIVE: begin
          if (handlerDone) begin
            if (bestValid) begin
              vecFetch  <= 1'b1;                      // [R03]
              tailChain <= 1'b1;                      // [R03]
              vecAddr   <= {23'h000000, bestVec, 2'b00};
              activeVec <= bestVec;
            end else begin
              state    <= ST_UNSTACK;
              wordCnt  <= 3'h0;
              stackPop <= 1'b1;                       // [R01]
            end
          end
        end
        ST_UNSTACK: begin
          if (wordCnt == `EVEEU_FRAME_WORDS) begin
            stackPop  <= 1'b0;
            inHandler <= 1'b0;
            activeVec <= 7'h00;
            state     <= ST_IDLE;
          end else begin
            wordCnt <= wordCnt + 3'h1;
          end
        end
        default: begin
          state     <= ST_IDLE;
          stackPush <= 1'b0;
          stackPop  <= 1'b0;
        end
      endcase
    end
  end

  // the system exception taken this cycle is retired from pending
  always @* begin
    sysTaken = 4'h0;
    if (clkEn && bestValid && (state == ST_IDLE || (state == ST_ACTIVE && handlerDone)))
      sysTaken = bestSys;
  end

endmodule // eveeu_top

// ### eveeu_core_model.sv
// processor core stand-in that ends each handler after a set delay
`timescale 1ns/1ps
module eveeu_core_model (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       inHandler,
  input  wire       stackPop,
  input  wire [3:0] delay,
  output reg        handlerDone
);
  reg [3:0] cnt;
  // pop phase excluded, else a returning frame would be ended twice
  always @(posedge ref_clk) begin
    if (srst || !inHandler || stackPop || handlerDone) begin
      cnt <= 4'h0;
      handlerDone <= 1'b0;
    end else if (cnt == delay) begin
      handlerDone <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // eveeu_core_model

// ### eveeu_top_sva.sv
// concurrent checks on the exception and edge event unit ports
`timescale 1ns/1ps
module eveeu_top_sva (
  input wire        ref_clk,
  input wire        srst,
  input wire        clkEn,
  input wire [3:0]  advTimerReq,
  input wire [1:0]  dma12Req,
  input wire        adcReq,
  input wire [1:0]  comparatorReq,
  input wire [1:0]  dma56Req,
  input wire        usbLowReq,
  input wire        handlerDone,
  input wire [51:0] irqReq,
  input wire [22:0] eventPulse,
  input wire        wakeReq,
  input wire        stackPush,
  input wire        stackPop,
  input wire        vecFetch,
  input wire [31:0] vecAddr,
  input wire [6:0]  activeVec,
  input wire        inHandler,
  input wire        tailChain
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // a frame is eight words, one a cycle
  sequence s_push8; stackPush [*8] ##1 !stackPush; endsequence
  sequence s_pop8; stackPop [*8] ##1 !stackPop; endsequence
  property p_push; $rose(stackPush) |-> s_push8; endproperty
  a_push: assert property (p_push) else $error("push frame length wrong");
  property p_pop; $rose(stackPop) |-> s_pop8; endproperty
  a_pop: assert property (p_pop) else $error("pop frame length wrong");
  property p_fetch; $rose(stackPush) |-> vecFetch; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not beside first push");
  property p_tail; tailChain |-> vecFetch && !stackPush && !stackPop; endproperty
  a_tail: assert property (p_tail) else $error("chain touched the stack");
  property p_chain; handlerDone && inHandler && !stackPop && (|irqReq) |=> tailChain && !stackPop; endproperty
  a_chain: assert property (p_chain) else $error("pending request not chained");
  property p_vec; vecFetch |-> activeVec != 7'h00 && vecAddr == {23'h0, activeVec, 2'h0}; endproperty
  a_vec: assert property (p_vec) else $error("vector address not number times four");
  // level sources reach their merged bit one cycle later; a frozen cycle updates nothing
  property p_merge;
    !$past(srst) && $past(clkEn) |-> irqReq[13] == $past(|advTimerReq) && irqReq[10] == $past(|dma12Req)
      && irqReq[12] == $past(adcReq || (|comparatorReq)) && irqReq[48] == $past(|dma56Req)
      && irqReq[37] == $past(usbLowReq);
  endproperty
  a_merge: assert property (p_merge) else $error("merged request wrong");
  property p_wake; (|eventPulse) |-> wakeReq; endproperty
  a_wake: assert property (p_wake) else $error("event without wake");
endmodule // eveeu_top_sva
bind eveeu_top eveeu_top_sva i_eveeu_top_sva (.ref_clk, .srst, .clkEn, .advTimerReq, .dma12Req, .adcReq, .comparatorReq,
  .dma56Req, .usbLowReq, .handlerDone, .irqReq, .eventPulse, .wakeReq, .stackPush, .stackPop, .vecFetch,
  .vecAddr, .activeVec, .inHandler, .tailChain);

// ### eveeu_top_tb.sv
// self-checking bench for the exception and edge event unit
`timescale 1ns/1ps
module eveeu_top_tb;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        clkEn = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [15:0] pinLine = 16'h0;
  logic [7:0]  internalLine = 8'h00;
  logic        busFaultReq = 1'b0, illegalUseReq = 1'b0, supervisorCallReq = 1'b0, pendServiceReq = 1'b0;
  logic [3:0]  advTimerReq = 4'h0, coreDelay = 4'h1;
  logic [1:0]  dma12Req = 2'h0, comparatorReq = 2'h0, dma56Req = 2'h0;
  logic        adcReq = 1'b0, usbLowReq = 1'b0;
  wire  [31:0] wb_dat_o, vecAddr;
  wire  [51:0] irqReq;
  wire  [22:0] eventPulse;
  wire  [6:0]  activeVec;
  wire         wb_ack_o, wakeReq, stackPush, stackPop, vecFetch, inHandler, tailChain, handlerDone;
  int          errorCnt = 0, checksDone = 0, tailCnt = 0, evCnt [23];
  logic [31:0] rdq;
  eveeu_top i_eveeu_top (.ref_clk, .srst, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .pinLine, .internalLine, .busFaultReq, .illegalUseReq, .supervisorCallReq,
    .pendServiceReq, .advTimerReq, .dma12Req, .adcReq, .comparatorReq, .dma56Req, .usbLowReq, .handlerDone,
    .irqReq, .eventPulse, .wakeReq, .stackPush, .stackPop, .vecFetch, .vecAddr, .activeVec, .inHandler, .tailChain);
  eveeu_core_model i_eveeu_core_model (.ref_clk, .srst, .inHandler, .stackPop, .delay(coreDelay), .handlerDone);
  // 200 MHz system clock
  initial forever #2.5 ref_clk = ~ref_clk;
  // pulses are counted so a doubled or lost one shows
  always @(posedge ref_clk) begin
    for (int i = 0; i < 23; i++) evCnt[i] <= evCnt[i] + int'(eventPulse[i]);
    tailCnt <= tailCnt + int'(tailChain);
  end
  task automatic endSim;
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checksDone++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tmo;
    errorCnt++;
    $display("[FAIL] %0t wait ran out", $time);
    endSim;
  endtask
  // classic cycle held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) tmo;
    rdq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e); bus(1'b0, a, 32'h0); chk(rdq, e); endtask
  task automatic waitVec;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (vecFetch !== 1'b1 && n < 60);
    if (n >= 60) tmo;
  endtask
  task automatic waitIdle;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (activeVec !== 7'h00 && n < 300);
    if (n >= 300) tmo;
  endtask
  task automatic t_regs;
    rd(8'h00, 32'h0);
    rd(8'h1c, 32'hf);
    rd(8'h20, 32'h0);
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h007fffff);
    wr(8'h08, 32'h0);
    wr(8'h18, 32'h4321);
    rd(8'h18, 32'h4321);
    rd(8'h40, 32'h0);
    $display("test regs done");
  endtask
  // line 0 rise, line 1 fall as event, line 2 both edges, line 16 internal
  task automatic t_edge;
    wr(8'h00, 32'h10005);
    wr(8'h04, 32'h6);
    wr(8'h08, 32'h10005);
    wr(8'h0c, 32'h6);
    @(posedge ref_clk);
    pinLine <= 16'h7;
    internalLine <= 8'h01;
    repeat (6) @(posedge ref_clk);
    rd(8'h14, 32'h10005);
    chk(irqReq[6:5], 2'b11);
    chk(irqReq[1], 1'b1);
    chk(evCnt[1], 0);
    chk(evCnt[2], 1);
    @(posedge ref_clk);
    pinLine <= 16'h0;
    internalLine <= 8'h00;
    repeat (6) @(posedge ref_clk);
    chk(evCnt[1], 1);
    chk(evCnt[2], 2);
    chk(evCnt[0], 0);
    rd(8'h14, 32'h10005);
    wr(8'h14, 32'h10005);
    rd(8'h14, 32'h0);
    $display("test edge done");
  endtask
  // line 3 has neither enable, so its trigger must vanish
  task automatic t_soft;
    wr(8'h00, 32'h40000);
    wr(8'h04, 32'h40000);
    wr(8'h10, 32'h40008);
    repeat (3) @(posedge ref_clk);
    chk(evCnt[18], 1);
    chk(evCnt[3], 0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h40000);
    chk(irqReq[42], 1'b1);
    wr(8'h14, 32'h40000);
    repeat (3) @(posedge ref_clk);
    chk(irqReq[42], 1'b0);
    waitIdle;
    $display("test soft done");
  endtask
  // frozen clock enable: a rise on line 4 is seen only once the block runs again
  task automatic t_hold;
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h10);
    @(posedge ref_clk);
    clkEn <= 1'b0;
    pinLine <= 16'h10;
    repeat (8) @(posedge ref_clk);
    chk(evCnt[4], 0);
    chk(wakeReq, 1'b0);
    clkEn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(evCnt[4], 1);
    pinLine <= 16'h0;
    @(posedge ref_clk);
    $display("test hold done");
  endtask
  task automatic t_exc;
    logic [6:0] vec [4] = '{7'h05, 7'h06, 7'h0b, 7'h0e};
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {pendServiceReq, supervisorCallReq, illegalUseReq, busFaultReq} <= 4'h1 << i;
      @(posedge ref_clk);
      {pendServiceReq, supervisorCallReq, illegalUseReq, busFaultReq} <= 4'h0;
      waitVec;
      chk(vecAddr, {23'h0, vec[i], 2'h0});
      chk(activeVec, vec[i]);
      waitIdle;
    end
    $display("test exceptions done");
  endtask
  // slow core, two requests at once: bus fault first, then a chain
  task automatic t_chain;
    int t0;
    t0 = tailCnt;
    coreDelay <= 4'h9;
    @(posedge ref_clk);
    {pendServiceReq, busFaultReq} <= 2'b11;
    @(posedge ref_clk);
    {pendServiceReq, busFaultReq} <= 2'b00;
    waitVec;
    chk(vecAddr, 32'h14);
    waitVec;
    chk(vecAddr, 32'h38);
    waitIdle;
    chk(tailCnt - t0, 1);
    $display("test chain done");
  endtask
  task automatic t_merge;
    int map [12] = '{37, 48, 48, 12, 12, 12, 10, 10, 13, 13, 13, 13};
    for (int j = 0; j < 12; j++) begin
      @(posedge ref_clk);
      {advTimerReq, dma12Req, adcReq, comparatorReq, dma56Req, usbLowReq} <= 12'h1 << j;
      repeat (2) @(posedge ref_clk);
      chk(irqReq, 52'h1 << map[j]);
      {advTimerReq, dma12Req, adcReq, comparatorReq, dma56Req, usbLowReq} <= 12'h0;
    end
    waitIdle;
    $display("test merge done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs;
    t_edge;
    t_soft;
    t_hold;
    t_exc;
    t_chain;
    t_merge;
    endSim;
  end
endmodule // eveeu_top_tb
